// ### vcd_pkg.sv
// Package of constants and carriers for the verify command block decoder
package vcd_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CDB0 = 8'h00;
  localparam logic [7:0] OFS_CDB7 = 8'h1C;
  localparam logic [7:0] OFS_CTRL = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_LBA_LO = 8'h28;
  localparam logic [7:0] OFS_LBA_HI = 8'h2C;
  localparam logic [7:0] OFS_LEN = 8'h30;
  localparam logic [7:0] OFS_REFTAG = 8'h34;
  localparam logic [7:0] OFS_APPTAG = 8'h38;
  localparam logic [7:0] OFS_FLAGS = 8'h3C;
  localparam logic [7:0] OFS_IRQ_STS = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h44;
  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_PROTECTION_ENABLED = 1;
  localparam int CTRL_PTYPE_LSB = 2;
  localparam int CTRL_ATO = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Interrupt status bits
  localparam int IRQ_DECODED = 0;
  localparam int IRQ_CHECK = 1;
  localparam int IRQ_EXEC = 2;
  localparam int IRQ_W = 3;
  // Command codes and fixed fields
  localparam logic [7:0] OP_VERIFY12 = 8'hAF;
  localparam logic [7:0] OP_VERIFY16 = 8'h8F;
  localparam logic [7:0] OP_VERIFY32 = 8'h7F;
  localparam logic [7:0] ADD_LEN32 = 8'h18;
  localparam logic [15:0] SA_VERIFY32 = 16'h000A;
  localparam logic [2:0] PTYPE_TYPE2 = 3'h1;
  localparam logic [2:0] SEL_RSVD_MIN = 3'h5;
  localparam logic [1:0] CMP_MEDIA = 2'h0;
  localparam logic [1:0] CMP_BYTE = 2'h1;
  localparam logic [1:0] CMP_UNDEF = 2'h2;
  localparam logic [1:0] CMP_SINGLE = 2'h3;
  // Sense keys and additional sense codes
  localparam logic [3:0] SK_NONE = 4'h0;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;
  localparam logic [3:0] SK_ABORTED = 4'hB;
  localparam logic [3:0] SK_MISCOMPARE = 4'hE;
  localparam logic [7:0] ASC_NONE = 8'h00;
  localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
  localparam logic [7:0] ASC_BAD_FIELD = 8'h24;
  localparam logic [7:0] ASC_PI_FAIL = 8'h10;
  localparam logic [7:0] ASC_MISCOMPARE = 8'h1D;
  // Failed protection field codes
  localparam logic [1:0] PI_OK = 2'h0;
  localparam logic [1:0] PI_GUARD = 2'h1;
  localparam logic [1:0] PI_APP = 2'h2;
  localparam logic [1:0] PI_REF = 2'h3;

  typedef enum logic [1:0] {KIND_NONE, KIND_12, KIND_16, KIND_32} vcd_kind_t;

  typedef struct packed {
    vcd_kind_t kind;
    logic [2:0] protect_check_select;
    logic low_retention_bit;
    logic force_media_access;
    logic [1:0] compare_mode;
    logic [63:0] lba;
    logic [31:0] len;
    logic [31:0] ref_tag;
    logic [15:0] app_tag;
    logic [15:0] app_mask;
    logic chk_guard;
    logic chk_app;
    logic chk_ref;
  } vcd_cmd_t;

  typedef struct packed {
    logic [3:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
  } vcd_sense_t;

  typedef struct packed {
    logic done;
    logic miscompare;
    logic [1:0] pi_field;
  } vcd_result_t;
endpackage : vcd_pkg

// ### vcd_decoder.sv
// Verify command block decoder with AHB-Lite register slave
//
// Overview of operation
// - 12-byte form: opcode AFh, byte 1 flags, address bytes 2-5, length 6-9.
// - 16-byte form: opcode 8Fh, address bytes 2-9, length 10-13, control byte 15.
// - 32-byte form: opcode 7Fh, length byte 18h, action 000Ah, group zero.
// - 32-byte form takes expected initial reference tag from bytes 20-23.
// - 32-byte form runs only on type 2 protection, else invalid opcode.
// - With tag owner set, mask bits enable application tag bit compares.
// - With tag owner clear, application tag and mask fields are ignored.
// - Protection checks follow the byte 1 selector (byte 10 in the 32-byte form) and the medium format.
// - Compare mode selects media check, byte compare or single-block compare.
// - Zero length moves no data and completes without error.
// - Selector values 101b-111b give Illegal Request, Invalid Field in CDB.
// - Failed protection check gives Aborted Command naming the failed field.
`timescale 1ns/10ps
`default_nettype none
module vcd_decoder (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  output vcd_pkg::vcd_cmd_t cmd,
  output logic cmd_valid,
  input wire vcd_pkg::vcd_result_t result
);
  typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_ISSUE, ST_EXEC} vcd_state_t;

  vcd_state_t state_q;
  logic [255:0] cdb_q;
  logic [31:0] ctrl_q;
  logic [vcd_pkg::IRQ_W-1:0] ists_q;
  logic [vcd_pkg::IRQ_W-1:0] ists_d;
  logic [vcd_pkg::IRQ_W-1:0] imask_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic irq_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic done_q;
  logic check_q;
  vcd_pkg::vcd_sense_t sense_q;
  vcd_pkg::vcd_cmd_t cmd_q;
  logic cmd_valid_q;
  vcd_pkg::vcd_cmd_t dec_cmd;
  vcd_pkg::vcd_sense_t dec_sense;
  logic dec_err;
  logic addr_ok;
  logic wr_now;
  logic start_req;
  logic [7:0] op;
  logic protection_enabled;
  logic [2:0] ptype;
  logic app_tag_owner;
  logic [2:0] sel;
  logic [1:0] cmpm;
  logic [7:0] ctl_byte1;
  logic [7:0] ctl_byte6;
  logic [7:0] ctl_byte10;

  // Byte i of the command block, byte 0 in the low lane of word 0
  function automatic logic [7:0] cb(input logic [255:0] c, input int i);
    cb = c[i*8 +: 8];
  endfunction : cb

  // Big-endian 32-bit field starting at byte i
  function automatic logic [31:0] be32(input logic [255:0] c, input int i);
    be32 = {cb(c, i), cb(c, i + 1), cb(c, i + 2), cb(c, i + 3)};
  endfunction : be32

  // Big-endian 16-bit field starting at byte i
  function automatic logic [15:0] be16(input logic [255:0] c, input int i);
    be16 = {cb(c, i), cb(c, i + 1)};
  endfunction : be16

  assign addr_ok = hsel && htrans[1] && hready;
  assign wr_now = wr_pend_q;
  assign start_req = wr_pend_q && (wr_addr_q == vcd_pkg::OFS_CTRL) &&
                     hwdata[vcd_pkg::CTRL_START] && (state_q == ST_IDLE);
  assign op = cb(cdb_q, 0);
  // Flag bytes named once, since a call result cannot be bit-selected
  assign ctl_byte1 = cb(cdb_q, 1);
  assign ctl_byte6 = cb(cdb_q, 6);
  assign ctl_byte10 = cb(cdb_q, 10);
  assign protection_enabled = ctrl_q[vcd_pkg::CTRL_PROTECTION_ENABLED];
  assign ptype = ctrl_q[vcd_pkg::CTRL_PTYPE_LSB +: 3];
  assign app_tag_owner = ctrl_q[vcd_pkg::CTRL_ATO];

  // Field extraction and validity checks, evaluated on the held block
  always_comb begin
    dec_cmd = '0;
    dec_sense = '{key: vcd_pkg::SK_NONE, asc: vcd_pkg::ASC_NONE, ascq: 8'h00};
    dec_err = 1'b0;
    sel = 3'h0;
    cmpm = 2'h0;
    case (op)
      vcd_pkg::OP_VERIFY12: begin
        dec_cmd.kind = vcd_pkg::KIND_12;
        sel = ctl_byte1[7:5];
        dec_cmd.low_retention_bit = ctl_byte1[4];
        dec_cmd.force_media_access = ctl_byte1[3];
        cmpm = ctl_byte1[2:1];
        dec_cmd.lba = {32'h0000_0000, be32(cdb_q, 2)};
        dec_cmd.len = be32(cdb_q, 6);
      end
      vcd_pkg::OP_VERIFY16: begin
        dec_cmd.kind = vcd_pkg::KIND_16;
        sel = ctl_byte1[7:5];
        dec_cmd.low_retention_bit = ctl_byte1[4];
        cmpm = ctl_byte1[2:1];
        dec_cmd.lba = {be32(cdb_q, 2), be32(cdb_q, 6)};
        dec_cmd.len = be32(cdb_q, 10);
      end
      vcd_pkg::OP_VERIFY32: begin
        dec_cmd.kind = vcd_pkg::KIND_32;
        sel = ctl_byte10[7:5];
        dec_cmd.low_retention_bit = ctl_byte10[4];
        cmpm = ctl_byte10[2:1];
        dec_cmd.lba = {be32(cdb_q, 12), be32(cdb_q, 16)};
        dec_cmd.ref_tag = be32(cdb_q, 20);
        dec_cmd.len = be32(cdb_q, 28);
        // Owner bit clear drops tag and mask so nothing downstream compares
        if (app_tag_owner) begin
          dec_cmd.app_tag = be16(cdb_q, 24);
          dec_cmd.app_mask = be16(cdb_q, 26);
        end
      end
      default: begin
        dec_cmd.kind = vcd_pkg::KIND_NONE;
      end
    endcase
    dec_cmd.protect_check_select = sel;
    dec_cmd.compare_mode = cmpm;
    // Per-field checks; application tag applies to the long form only
    case (sel)
      3'h0: begin
        dec_cmd.chk_guard = protection_enabled;
        dec_cmd.chk_ref = protection_enabled;
        dec_cmd.chk_app = protection_enabled && (dec_cmd.kind == vcd_pkg::KIND_32) && app_tag_owner;
      end
      3'h1: begin
        dec_cmd.chk_guard = 1'b1;
        dec_cmd.chk_ref = 1'b1;
        dec_cmd.chk_app = (dec_cmd.kind == vcd_pkg::KIND_32) && app_tag_owner;
      end
      3'h2: begin
        dec_cmd.chk_ref = 1'b1;
        dec_cmd.chk_app = (dec_cmd.kind == vcd_pkg::KIND_32) && app_tag_owner;
      end
      3'h4: begin
        dec_cmd.chk_guard = 1'b1;
      end
      default: begin
        dec_cmd.chk_guard = 1'b0;
      end
    endcase
    // Error priority: opcode, then format, then field checks
    if (dec_cmd.kind == vcd_pkg::KIND_NONE) begin
      dec_err = 1'b1;
      dec_sense.asc = vcd_pkg::ASC_BAD_OPCODE;
    end else if ((dec_cmd.kind == vcd_pkg::KIND_32) &&
                 (be16(cdb_q, 8) != vcd_pkg::SA_VERIFY32)) begin
      dec_err = 1'b1;
      dec_sense.asc = vcd_pkg::ASC_BAD_OPCODE;
    end else if ((dec_cmd.kind == vcd_pkg::KIND_32) &&
                 !(protection_enabled && (ptype == vcd_pkg::PTYPE_TYPE2))) begin
      dec_err = 1'b1;
      dec_sense.asc = vcd_pkg::ASC_BAD_OPCODE;
    end else if (((dec_cmd.kind == vcd_pkg::KIND_32) &&
                  ((cb(cdb_q, 7) != vcd_pkg::ADD_LEN32) || (ctl_byte6[4:0] != 5'h00))) ||
                 (sel >= vcd_pkg::SEL_RSVD_MIN) || (!protection_enabled && (sel != 3'h0)) ||
                 (cmpm == vcd_pkg::CMP_UNDEF)) begin
      dec_err = 1'b1;
      dec_sense.asc = vcd_pkg::ASC_BAD_FIELD;
    end
    if (dec_err) begin
      dec_sense.key = vcd_pkg::SK_ILLEGAL;
    end
  end

  // Command sequencer: decode, then hand over or finish at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_req) begin
            state_q <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          // A zero length is finished here without touching the datapath
          if (dec_err || (dec_cmd.len == 32'h0000_0000)) begin
            state_q <= ST_IDLE;
          end else begin
            state_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          state_q <= ST_EXEC;
        end
        ST_EXEC: begin
          if (result.done) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Decoded command and its one-cycle issue strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q <= '0;
      cmd_valid_q <= 1'b0;
    end else begin
      cmd_valid_q <= (state_q == ST_DECODE) && !dec_err && (dec_cmd.len != 32'h0000_0000);
      if (state_q == ST_DECODE) begin
        cmd_q <= dec_cmd;
      end
    end
  end

  // Completion status and sense data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
      check_q <= 1'b0;
      sense_q <= '0;
    end else if (start_req) begin
      done_q <= 1'b0;
      check_q <= 1'b0;
      sense_q <= '0;
    end else if (state_q == ST_DECODE) begin
      done_q <= dec_err || (dec_cmd.len == 32'h0000_0000);
      check_q <= dec_err;
      sense_q <= dec_sense;
    end else if ((state_q == ST_EXEC) && result.done) begin
      done_q <= 1'b1;
      if (result.pi_field != vcd_pkg::PI_OK) begin
        check_q <= 1'b1;
        sense_q <= '{key: vcd_pkg::SK_ABORTED, asc: vcd_pkg::ASC_PI_FAIL,
                     ascq: {6'h00, result.pi_field}};
      end else if (result.miscompare && (cmd_q.compare_mode != vcd_pkg::CMP_MEDIA)) begin
        check_q <= 1'b1;
        sense_q <= '{key: vcd_pkg::SK_MISCOMPARE, asc: vcd_pkg::ASC_MISCOMPARE,
                     ascq: 8'h00};
      end
    end
  end

  // Bus address phase is latched; writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // Block bytes are frozen while a command is in flight
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cdb_q <= '0;
    end else if (wr_now && (wr_addr_q <= vcd_pkg::OFS_CDB7) && (state_q == ST_IDLE) &&
                 (wr_addr_q[1:0] == 2'h0)) begin
      cdb_q[wr_addr_q[4:2]*32 +: 32] <= hwdata;
    end
  end

  // Configuration; start bit reads back as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= vcd_pkg::CTRL_RESET;
      imask_q <= '0;
    end else if (wr_now) begin
      if (wr_addr_q == vcd_pkg::OFS_CTRL) begin
        ctrl_q <= {26'h0, hwdata[5:1], 1'b0};
      end
      if (wr_addr_q == vcd_pkg::OFS_IRQ_MASK) begin
        imask_q <= hwdata[vcd_pkg::IRQ_W-1:0];
      end
    end
  end

  // Sticky events; a new event beats a same-cycle write-one clear
  always_comb begin
    ists_d = ists_q;
    if (wr_now && (wr_addr_q == vcd_pkg::OFS_IRQ_STS)) begin
      ists_d = ists_q & ~hwdata[vcd_pkg::IRQ_W-1:0];
    end
    if (state_q == ST_DECODE) begin
      ists_d[vcd_pkg::IRQ_DECODED] = 1'b1;
      ists_d[vcd_pkg::IRQ_CHECK] = ists_d[vcd_pkg::IRQ_CHECK] | dec_err;
    end
    if ((state_q == ST_EXEC) && result.done) begin
      ists_d[vcd_pkg::IRQ_EXEC] = 1'b1;
      ists_d[vcd_pkg::IRQ_CHECK] = ists_d[vcd_pkg::IRQ_CHECK] |
                                   (result.pi_field != vcd_pkg::PI_OK) |
                                   (result.miscompare &&
                                    (cmd_q.compare_mode != vcd_pkg::CMP_MEDIA));
    end
  end

  // Interrupt state and level output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ists_q <= '0;
      irq_q <= 1'b0;
    end else begin
      ists_q <= ists_d;
      irq_q <= |(ists_d & imask_q);
    end
  end

  // Read data prepared in the address phase, so no wait states are needed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
    end else begin
      hreadyout_q <= 1'b1;
      if (addr_ok && !hwrite) begin
        case (haddr[7:0])
          vcd_pkg::OFS_CTRL: hrdata_q <= ctrl_q;
          vcd_pkg::OFS_STATUS: hrdata_q <= {8'h00, sense_q.ascq, sense_q.asc, sense_q.key,
                                            1'b0, (state_q != ST_IDLE), check_q, done_q};
          vcd_pkg::OFS_LBA_LO: hrdata_q <= cmd_q.lba[31:0];
          vcd_pkg::OFS_LBA_HI: hrdata_q <= cmd_q.lba[63:32];
          vcd_pkg::OFS_LEN: hrdata_q <= cmd_q.len;
          vcd_pkg::OFS_REFTAG: hrdata_q <= cmd_q.ref_tag;
          vcd_pkg::OFS_APPTAG: hrdata_q <= {cmd_q.app_mask, cmd_q.app_tag};
          vcd_pkg::OFS_FLAGS: hrdata_q <= {20'h0, cmd_q.chk_ref, cmd_q.chk_app, cmd_q.chk_guard,
                                           cmd_q.compare_mode, cmd_q.force_media_access,
                                           cmd_q.low_retention_bit,
                                           cmd_q.protect_check_select, cmd_q.kind};
          vcd_pkg::OFS_IRQ_STS: hrdata_q <= {29'h0, ists_q};
          vcd_pkg::OFS_IRQ_MASK: hrdata_q <= {29'h0, imask_q};
          default: begin
            // Block bytes readable; anything unmapped reads zero
            if (haddr[7:0] <= vcd_pkg::OFS_CDB7) begin
              hrdata_q <= cdb_q[haddr[4:2]*32 +: 32];
            end else begin
              hrdata_q <= 32'h0000_0000;
            end
          end
        endcase
      end
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign irq = irq_q;
  assign cmd = cmd_q;
  assign cmd_valid = cmd_valid_q;

  // Checks on decode and completion
  sequence s_decode_ok;
    (state_q == ST_DECODE) && !dec_err;
  endsequence
  sequence s_issue;
    ##1 cmd_valid_q ##1 (state_q == ST_EXEC);
  endsequence

  property p_op12;
    @(posedge hclk) disable iff (!hresetn)
    s_decode_ok and (op == vcd_pkg::OP_VERIFY12) |=>
      (cmd_q.lba == {32'h0000_0000, be32($past(cdb_q), 2)}) && (cmd_q.kind == vcd_pkg::KIND_12);
  endproperty
  a_op12: assert property (p_op12) else $error("short form address wrong");
  property p_op16;
    @(posedge hclk) disable iff (!hresetn)
    s_decode_ok and (op == vcd_pkg::OP_VERIFY16) |=> cmd_q.len == be32($past(cdb_q), 10);
  endproperty
  a_op16: assert property (p_op16) else $error("medium form length wrong");
  property p_sa;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == ST_DECODE) && (op == vcd_pkg::OP_VERIFY32) &&
    (be16(cdb_q, 8) != vcd_pkg::SA_VERIFY32) |=> check_q && (sense_q.key == vcd_pkg::SK_ILLEGAL);
  endproperty
  a_sa: assert property (p_sa) else $error("bad service action accepted");
  property p_ref;
    @(posedge hclk) disable iff (!hresetn)
    s_decode_ok and (op == vcd_pkg::OP_VERIFY32) |=> cmd_q.ref_tag == be32($past(cdb_q), 20);
  endproperty
  a_ref: assert property (p_ref) else $error("reference tag wrong");
  property p_type2;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == ST_DECODE) && (op == vcd_pkg::OP_VERIFY32) && (ptype != vcd_pkg::PTYPE_TYPE2) |=>
      check_q && done_q && (sense_q.asc == vcd_pkg::ASC_BAD_OPCODE) && !cmd_valid_q;
  endproperty
  a_type2: assert property (p_type2) else $error("wrong format not refused");
  property p_ato;
    @(posedge hclk) disable iff (!hresetn)
    s_decode_ok and !app_tag_owner |=> (cmd_q.app_mask == 16'h0000) && !cmd_q.chk_app;
  endproperty
  a_ato: assert property (p_ato) else $error("tag fields used without owner");
  property p_zero;
    @(posedge hclk) disable iff (!hresetn)
    s_decode_ok and (dec_cmd.len == 32'h0000_0000) |=> done_q && !check_q && !cmd_valid_q;
  endproperty
  a_zero: assert property (p_zero) else $error("zero length not clean");
  property p_go;
    @(posedge hclk) disable iff (!hresetn)
    s_decode_ok and (dec_cmd.len != 32'h0000_0000) |-> s_issue;
  endproperty
  a_go: assert property (p_go) else $error("command not issued");
  property p_cmp;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == ST_EXEC) && result.done && result.miscompare &&
    (result.pi_field == vcd_pkg::PI_OK) && (cmd_q.compare_mode != vcd_pkg::CMP_MEDIA) |=>
      check_q && (sense_q.key == vcd_pkg::SK_MISCOMPARE);
  endproperty
  a_cmp: assert property (p_cmp) else $error("miscompare not reported");
  property p_rsvd;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == ST_DECODE) && (sel >= vcd_pkg::SEL_RSVD_MIN) |=> check_q &&
      (sense_q.key == vcd_pkg::SK_ILLEGAL) && (state_q == ST_IDLE);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved selector accepted");
  property p_pi;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == ST_EXEC) && result.done && (result.pi_field != vcd_pkg::PI_OK) |=>
      (sense_q.key == vcd_pkg::SK_ABORTED) && (sense_q.ascq[1:0] == $past(result.pi_field))
      ##1 irq_q || !imask_q[vcd_pkg::IRQ_CHECK];
  endproperty
  a_pi: assert property (p_pi) else $error("protection failure not reported");
endmodule : vcd_decoder
`default_nettype wire

// ### vcd_datapath_model.sv
// Behavioural datapath model that answers issued verify commands
`timescale 1ns/10ps
`default_nettype none
module vcd_datapath_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cmd_valid,
  input wire logic [7:0] answer_delay,
  input wire logic answer_miscompare,
  input wire logic [1:0] answer_pi_field,
  output vcd_pkg::vcd_result_t result
);
  logic [7:0] wait_q;
  logic busy_q;
  logic noise_q;
  // Fields toggle outside the done cycle so stale values never look valid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q <= 1'b0;
      wait_q <= 8'h00;
      noise_q <= 1'b0;
      result <= '0;
    end else begin
      noise_q <= ~noise_q;
      result.done <= 1'b0;
      result.miscompare <= noise_q;
      result.pi_field <= {noise_q, ~noise_q};
      if (cmd_valid) begin
        busy_q <= 1'b1;
        wait_q <= answer_delay;
      end else if (busy_q && wait_q == 8'h00) begin
        busy_q <= 1'b0;
        result.done <= 1'b1;
        result.miscompare <= answer_miscompare;
        result.pi_field <= answer_pi_field;
      end else if (busy_q) begin
        wait_q <= wait_q - 8'h01;
      end
    end
  end
endmodule : vcd_datapath_model
`default_nettype wire

// ### tb_vcd_decoder.sv
// Self-checking bench for the verify command block decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_vcd_decoder;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, cmd_valid, hready, mis;
  logic [31:0] haddr, hwdata, hrdata, st, r;
  logic [1:0] htrans, pi;
  logic [2:0] hsize;
  logic [7:0] dly;
  logic [7:0] c [32];
  vcd_pkg::vcd_cmd_t cmd;
  vcd_pkg::vcd_result_t result;
  int fail_count, tests_run, nvalid, nv0, i;
  localparam logic [7:0] CT2 = 8'h07;
  localparam logic [7:0] CT2A = 8'h27;
  localparam logic [7:0] CT0 = 8'h03;
  logic [3:0] sk [4] = '{vcd_pkg::SK_NONE, vcd_pkg::SK_MISCOMPARE, vcd_pkg::SK_ILLEGAL,
    vcd_pkg::SK_MISCOMPARE};
  logic [7:0] as [4] = '{vcd_pkg::ASC_NONE, vcd_pkg::ASC_MISCOMPARE, vcd_pkg::ASC_BAD_FIELD,
    vcd_pkg::ASC_MISCOMPARE};
  logic [2:0] ec [5] = '{3'b111, 3'b111, 3'b011, 3'b000, 3'b100};
  assign hready = hreadyout;
  vcd_decoder uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .cmd(cmd),
    .cmd_valid(cmd_valid), .result(result));
  vcd_datapath_model peer (.hclk(hclk), .hresetn(hresetn), .cmd_valid(cmd_valid),
    .answer_delay(dly), .answer_miscompare(mis), .answer_pi_field(pi), .result(result));
  // 50 MHz clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // Count issued commands
  always @(posedge hclk) if (cmd_valid === 1'b1) nvalid++;
  // Hang guard, far beyond the expected run length
  initial begin
    repeat (40000) @(posedge hclk);
    fail_count++;
    test_done();
  end
  task test_done();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  // Single AHB-Lite transfer; waits for ready with no assumed latency
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : ahb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] q);
    ahb(1'b0, a, 32'h0, q);
  endtask : rd
  // Big-endian field into the command block
  task put(input int idx, input int n, input logic [63:0] v);
    for (int k = 0; k < n; k++) c[idx + k] = v[8 * (n - 1 - k) +: 8];
  endtask : put
  task cdb12(input logic [7:0] b1, input logic [31:0] lba, input logic [31:0] len);
    foreach (c[k]) c[k] = 8'h00;
    c[0] = vcd_pkg::OP_VERIFY12;
    c[1] = b1;
    put(2, 4, {32'h0, lba});
    put(6, 4, {32'h0, len});
  endtask : cdb12
  task cdb32(input logic [2:0] sel);
    foreach (c[k]) c[k] = 8'h00;
    c[0] = vcd_pkg::OP_VERIFY32;
    c[7] = vcd_pkg::ADD_LEN32;
    c[9] = 8'h0A;
    c[10] = {sel, 5'h00};
    put(12, 8, 64'h0000_0001_0000_0002);
    put(20, 4, 64'hCAFE_0001);
    put(24, 2, 64'h1234);
    put(26, 2, 64'hF0F0);
    put(28, 4, 64'h8);
  endtask : cdb32
  // Load block, start, then poll status until the command has finished
  task run(input logic [7:0] ctl);
    for (int k = 0; k < 8; k++) wr(8'(4 * k), {c[4*k+3], c[4*k+2], c[4*k+1], c[4*k]});
    nv0 = nvalid;
    wr(vcd_pkg::OFS_CTRL, {24'h000000, ctl});
    repeat (2) @(posedge hclk);
    st = 32'h0;
    while (st[0] !== 1'b1 || st[2] !== 1'b0) rd(vcd_pkg::OFS_STATUS, st);
  endtask : run
  task sense(input logic [3:0] k, input logic [7:0] a, input logic [7:0] q);
    `CHK("check", (k != 4'h0), st[1])
    `CHK("key", k, st[7:4])
    `CHK("asc", a, st[15:8])
    `CHK("ascq", q, st[23:16])
    `CHK("hresp", 1'b0, hresp)
    `CHK("hreadyout", 1'b1, hreadyout)
  endtask : sense
  task fired(input int n);
    `CHK("issued", n, nvalid - nv0)
  endtask : fired
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    mis = 1'b1;
    pi = 2'h0;
    dly = 8'h00;
    repeat (8) @(posedge hclk);
    `CHK("rst_irq", 1'b0, irq)
    `CHK("rst_valid", 1'b0, cmd_valid)
    hresetn <= 1'b1;
    rd(vcd_pkg::OFS_CTRL, r);
    `CHK("ctrl_rst", vcd_pkg::CTRL_RESET, r)
    rd(8'hF0, r);
    `CHK("unmapped", 32'h0, r)
    wr(vcd_pkg::OFS_IRQ_STS, 32'h7);
    wr(vcd_pkg::OFS_IRQ_MASK, 32'h1);
    // Every compare mode while the datapath reports a miscompare
    for (i = 0; i < 4; i++) begin
      cdb12(8'h18 | 8'(i << 1), 32'h1234_5678, 32'h10);
      run(CT2);
      sense(sk[i], as[i], 8'h00);
    end
    mis <= 1'b0;
    dly <= 8'd20;
    cdb12(8'h1A, 32'h1234_5678, 32'h10);
    run(CT2);
    sense(vcd_pkg::SK_NONE, vcd_pkg::ASC_NONE, 8'h00);
    fired(1);
    `CHK("kind12", vcd_pkg::KIND_12, cmd.kind)
    `CHK("lba12", 64'h1234_5678, cmd.lba)
    `CHK("len12", 32'h10, cmd.len)
    `CHK("retain", 1'b1, cmd.low_retention_bit)
    `CHK("force", 1'b1, cmd.force_media_access)
    rd(vcd_pkg::OFS_FLAGS, r);
    `CHK("flags", 32'h0000_0AE1, r)
    // Interrupt raise, mask and clear
    rd(vcd_pkg::OFS_IRQ_STS, r);
    `CHK("ists", 1'b1, r[0])
    `CHK("irq_on", 1'b1, irq)
    wr(vcd_pkg::OFS_IRQ_MASK, 32'h0);
    rd(vcd_pkg::OFS_IRQ_STS, r);
    `CHK("irq_masked", 1'b0, irq)
    wr(vcd_pkg::OFS_IRQ_MASK, 32'h1);
    wr(vcd_pkg::OFS_IRQ_STS, 32'h1);
    rd(vcd_pkg::OFS_IRQ_STS, r);
    `CHK("ists_clr", 1'b0, r[0])
    `CHK("irq_clr", 1'b0, irq)
    cdb12(8'h00, 32'h5, 32'h0);
    run(CT2);
    sense(vcd_pkg::SK_NONE, vcd_pkg::ASC_NONE, 8'h00);
    fired(0);
    for (i = 5; i < 8; i++) begin
      cdb12(8'(i << 5), 32'h1, 32'h1);
      run(CT2);
      sense(vcd_pkg::SK_ILLEGAL, vcd_pkg::ASC_BAD_FIELD, 8'h00);
    end
    foreach (c[k]) c[k] = 8'h00;
    c[0] = vcd_pkg::OP_VERIFY16;
    put(2, 8, 64'h0102_0304_0506_0708);
    put(10, 4, 64'h100);
    run(CT2);
    `CHK("kind16", vcd_pkg::KIND_16, cmd.kind)
    `CHK("lba16", 64'h0102_0304_0506_0708, cmd.lba)
    `CHK("len16", 32'h100, cmd.len)
    rd(vcd_pkg::OFS_LBA_HI, r);
    `CHK("lba_hi", 32'h0102_0304, r)
    dly <= 8'd0;
    for (i = 1; i < 4; i++) begin
      pi <= 2'(i);
      cdb32(3'h1);
      run(CT2A);
      sense(vcd_pkg::SK_ABORTED, vcd_pkg::ASC_PI_FAIL, 8'(i));
    end
    pi <= 2'h0;
    `CHK("kind32", vcd_pkg::KIND_32, cmd.kind)
    `CHK("reftag", 32'hCAFE_0001, cmd.ref_tag)
    rd(vcd_pkg::OFS_APPTAG, r);
    `CHK("apptag", 32'hF0F0_1234, r)
    for (i = 0; i < 5; i++) begin
      cdb32(3'(i));
      run(CT2A);
      `CHK("checks", ec[i], {cmd.chk_guard, cmd.chk_app, cmd.chk_ref})
    end
    cdb32(3'h1);
    run(CT2);
    rd(vcd_pkg::OFS_APPTAG, r);
    `CHK("app_off", 32'h0, r)
    `CHK("chkapp_off", 1'b0, cmd.chk_app)
    run(CT0);
    sense(vcd_pkg::SK_ILLEGAL, vcd_pkg::ASC_BAD_OPCODE, 8'h00);
    fired(0);
    c[9] = 8'h0B;
    run(CT2A);
    sense(vcd_pkg::SK_ILLEGAL, vcd_pkg::ASC_BAD_OPCODE, 8'h00);
    c[9] = 8'h0A;
    c[7] = 8'h17;
    run(CT2A);
    sense(vcd_pkg::SK_ILLEGAL, vcd_pkg::ASC_BAD_FIELD, 8'h00);
    c[7] = vcd_pkg::ADD_LEN32;
    c[6] = 8'h01;
    run(CT2A);
    sense(vcd_pkg::SK_ILLEGAL, vcd_pkg::ASC_BAD_FIELD, 8'h00);
    test_done();
  end
endmodule : tb_vcd_decoder
`default_nettype wire
